// File: hdl/bfi_core.sv
// Purpose: breaker failure initiation, delay stages and trip outputs
// Assumes: inputs are raw pins or settings, all synchronised here
// Notes:   current detection arrives as per-phase flags
`timescale 1ns/1ps
// What this block does
// - Trip plus current starts common-phase timers
// - No current: use auxiliary contacts instead
// - Breaker open: no current or NC closed
// - Any pole closed raises some_pole_shut
// - No-current start judged by contacts only
// - External or internal block suppresses initiation
// - Assigned release gates every start
// - Segregated mode evaluates each phase alone
// - Single-phase start: that phase only, current
// - Segregated contact check only when enabled
// - No per-pole contacts: NO chain open
// - Multi-pole trip gives three-phase start
// - No-current start always three-phase
// - Segregated single-pole trip watches tripped pole, or NO chain without per-pole contacts
// - Separate timers per initiation, plus second stage
// - Adjacent trips are always three-pole
// - Single-stage: adjacent trip follows second timer, or first-stage timers when cfg_split_t1 is set
// - Two-stage: retrip local, then trip adjacent
// - First delay by trip type; retrip select
// - Inoperable breaker timer trips adjacent
// - Adjacent trip routed to intertrip output
// - Seen current then gone means open
module bfi_core
   import bfi_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            sys_rst,
   // Settings
   input  wire logic            cfg_segregated,
   input  wire logic            cfg_two_stage,
   input  wire logic            cfg_split_t1,
   input  wire logic            use_aux_contact_check,
   input  wire logic            retrip_single_pole_select,
   input  wire logic            cfg_release_assigned,
   input  wire logic            cfg_per_pole_aux,
   input  wire logic            int_block,
   // Feeder protection starts
   input  wire logic            int_trip_all,
   input  wire logic [NPH-1:0]  int_trip_phase,
   input  wire logic            int_start_no_current,
   input  wire logic            ext_start_all_phases,
   input  wire logic            ext_start_phase_a,
   input  wire logic            ext_start_phase_b,
   input  wire logic            ext_start_phase_c,
   input  wire logic            ext_start_no_current,
   input  wire logic            ext_release_in,
   input  wire logic            ext_block_in,
   input  wire logic            breaker_inoperable_in,
   // Breaker state
   input  wire logic [NPH-1:0]  current_flow,
   input  wire logic [NPH-1:0]  pole_shut_in,
   input  wire logic            aux_valid,
   input  wire logic            no_chain_shut,
   // Outputs
   output logic                 some_pole_shut,
   output logic                 all_phase_start,
   output logic [NPH-1:0]       single_phase_start,
   output logic [NPH-1:0]       local_retrip,
   output logic                 adjacent_trip,
   output logic                 intertrip_out,
   output logic [2:0]           stage_state
);
   // Two-flop synchronisers for every pin and setting
   // Seventeen single pins plus four per-phase groups
   localparam int SW = 4 * NPH + 17;
   logic [SW-1:0] raw, s1, s2;
   assign raw = {cfg_segregated, cfg_two_stage, cfg_split_t1,
                 use_aux_contact_check, retrip_single_pole_select,
                 cfg_release_assigned, cfg_per_pole_aux, int_block,
                 int_trip_all, int_trip_phase, int_start_no_current,
                 ext_start_all_phases, ext_start_phase_c,
                 ext_start_phase_b, ext_start_phase_a,
                 ext_start_no_current, ext_release_in, ext_block_in,
                 breaker_inoperable_in, current_flow, pole_shut_in,
                 aux_valid, no_chain_shut};
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
      end
   end

   logic seg, two_st, split, chk, rsel, rel_as, ppa, iblk;
   logic itrip3, inocur, xtrip3, xnocur, xrel, xblk, inop, auxv, nochn;
   logic [NPH-1:0] itrip, xtrip, cur, pshut;
   assign {seg, two_st, split, chk, rsel, rel_as, ppa, iblk, itrip3,
           itrip, inocur, xtrip3, xtrip, xnocur, xrel, xblk, inop,
           cur, pshut, auxv, nochn} = s2;

   // Combined start conditions
   logic [NPH-1:0] trip_ph;
   logic trip_any, multi, released, nocur_start, any_cur;
   logic shut_any, all_open_aux;
   assign trip_ph  = itrip | xtrip;
   assign multi    = (trip_ph[0] & trip_ph[1]) | (trip_ph[1] & trip_ph[2])
                     | (trip_ph[0] & trip_ph[2]);
   assign released = (!rel_as || xrel) && !xblk && !iblk;
   assign trip_any = itrip3 | xtrip3 | (|trip_ph);
   assign nocur_start = inocur | xnocur;
   assign any_cur  = |cur;
   assign shut_any = |pshut;
   assign all_open_aux = auxv && !shut_any;

   // Current seen during this trip latch, per phase
   logic [NPH-1:0] cur_seen;
   always_ff @(posedge mclk) begin
      if (sys_rst || !trip_any) begin
         cur_seen <= '0;
      end else begin
         cur_seen <= cur_seen | cur;
      end
   end

   // Common-phase initiate: current, else contacts if not seen current
   logic init_cp, init_3ph;
   always_comb begin
      init_cp = 1'b0;
      if (released) begin
         if (nocur_start) begin
            init_cp = auxv && shut_any;
         end else if (!seg || multi || itrip3 || xtrip3) begin
            if (trip_any && any_cur) begin
               init_cp = 1'b1;
            end else if (trip_any && !(|cur_seen)) begin
               init_cp = chk && auxv && shut_any;
            end
         end
      end
   end
   assign init_3ph = init_cp;

   // Phase-segregated initiate, one per phase
   logic [NPH-1:0] init_ph;
   genvar g;
   generate
      for (g = 0; g < NPH; g++) begin : g_ph
         logic only_this, pole_closed;
         assign only_this = trip_ph[g] && !multi && !itrip3 && !xtrip3
                            && !nocur_start;
         // Without per-pole contacts, NO chain tells the pole state
         assign pole_closed = ppa ? pshut[g] : nochn;
         assign init_ph[g] = seg && released && only_this &&
            (cur[g] || (!cur_seen[g] && chk && auxv && pole_closed));
      end
   endgenerate

   // Delay timers
   bfi_tmr_if t_one ();
   bfi_tmr_if t_all ();
   bfi_tmr_if t_two ();
   bfi_tmr_if t_inop ();

   logic stage1_hit;
   always_comb begin
      stage1_hit = t_one.done | t_all.done;
   end

   // First stage: segregated and common-phase delays
   assign t_one.run   = |init_ph;
   assign t_one.limit = T1_ONE_CYC;
   assign t_all.run   = init_3ph;
   assign t_all.limit = T1_ALL_CYC;
   // Second stage runs on any initiation; single-stage without split uses it alone
   assign t_two.run   = (|init_ph) | init_3ph;
   assign t_two.limit = T2_CYC;
   // Release gates this start as well, like every other
   assign t_inop.run  = inop && trip_any && released;
   assign t_inop.limit = T3_CYC;

   bfi_timer u_t_one (.mclk(mclk), .sys_rst(sys_rst), .t(t_one));
   bfi_timer u_t_all (.mclk(mclk), .sys_rst(sys_rst), .t(t_all));
   bfi_timer u_t_two (.mclk(mclk), .sys_rst(sys_rst), .t(t_two));
   bfi_timer u_t_inop (.mclk(mclk), .sys_rst(sys_rst), .t(t_inop));

   // Stage tracker for status
   bfi_stage_t stage;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stage <= BFI_IDLE;
      end else begin
         case (stage)
            BFI_IDLE: begin
               if (t_two.run) stage <= BFI_ARMED;
            end
            BFI_ARMED: begin
               if (adjacent_trip) stage <= BFI_FIRED;
               else if (!t_two.run) stage <= BFI_IDLE;
            end
            BFI_FIRED: begin
               if (!t_two.run && !t_inop.run) stage <= BFI_IDLE;
            end
            default: stage <= BFI_IDLE;
         endcase
      end
   end

   // Adjacent trip decision
   logic next_adj;
   always_comb begin
      next_adj = t_inop.done;
      if (two_st) begin
         next_adj = next_adj | t_two.done;
      end else if (split) begin
         next_adj = next_adj | stage1_hit;
      end else begin
         next_adj = next_adj | t_two.done;
      end
   end

   // Local retrip, single or three pole
   logic [NPH-1:0] next_retrip;
   always_comb begin
      next_retrip = '0;
      if (two_st) begin
         if (t_all.done) begin
            next_retrip = '1;
         end else if (t_one.done) begin
            next_retrip = rsel ? init_ph : '1;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         some_pole_shut     <= 1'b0;
         all_phase_start    <= 1'b0;
         single_phase_start <= '0;
         local_retrip       <= '0;
         adjacent_trip      <= 1'b0;
         intertrip_out      <= 1'b0;
         stage_state        <= BFI_IDLE;
      end else begin
         some_pole_shut     <= shut_any;
         all_phase_start    <= init_3ph;
         single_phase_start <= init_ph;
         local_retrip       <= next_retrip;
         adjacent_trip      <= next_adj;
         intertrip_out      <= next_adj;
         stage_state        <= stage;
      end
   end
endmodule

// File: hdl/bfi_pkg.sv
// Purpose: shared constants and types for breaker failure initiation
// Assumes: 250 MHz mclk; delays given in microseconds
// Notes:   delay counts are derived from the time figures
package bfi_pkg;
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned CNT_W          = 32;
   // Default delay times in microseconds
   localparam int unsigned T2_US          = 150000;
   localparam int unsigned T1_ONE_US      = 100000;
   localparam int unsigned T1_ALL_US      = 100000;
   localparam int unsigned T3_US          = 0;
   localparam logic [CNT_W-1:0] T2_CYC     = CNT_W'(T2_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] T1_ONE_CYC = CNT_W'(T1_ONE_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] T1_ALL_CYC = CNT_W'(T1_ALL_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] T3_CYC     = CNT_W'(T3_US * CLK_MHZ);
   localparam int unsigned NPH            = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
   localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
   typedef enum logic [2:0] {
      BFI_IDLE   = 3'b001,
      BFI_ARMED  = 3'b010,
      BFI_FIRED  = 3'b100
   } bfi_stage_t;
endpackage

// File: hdl/bfi_timer.sv
// Purpose: one delay stage; counts while run, clears when run drops
// Assumes: limit stable while run is high
// Notes:   a zero limit expires one cycle after run rises
`timescale 1ns/1ps
module bfi_timer
   import bfi_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control link
   bfi_tmr_if.tmr   t
);
   logic [CNT_W-1:0] count;

   always_ff @(posedge mclk) begin
      if (sys_rst || !t.run) begin
         count  <= CNT_ZERO;
         t.done <= 1'b0;
      end else if (count >= t.limit) begin
         t.done <= 1'b1;
      end else begin
         count  <= count + CNT_ONE;
      end
   end
endmodule

// File: hdl/bfi_tmr_if.sv
// Purpose: start/expiry link between control and a delay timer
// Assumes: single clock domain
// Notes:   run held high while the timer should keep counting
`timescale 1ns/1ps
interface bfi_tmr_if;
   import bfi_pkg::*;
   logic             run;
   logic [CNT_W-1:0] limit;
   logic             done;
   modport ctl (output run, output limit, input done);
   modport tmr (input run, input limit, output done);
endinterface

// File: testbench/bfi_breaker_model.sv
// Purpose: breaker poles, fault current and auxiliary contacts
// Assumes: a pole opens two edges after it is asked to
// Notes:   stuck contacts keep reporting closed after opening
`timescale 1ns/1ps
module bfi_breaker_model (
   // Clock
   input  wire logic       mclk,
   // Stimulus
   input  wire logic [2:0] fault,
   input  wire logic [2:0] open_req,
   input  wire logic       aux_stuck,
   // Breaker side
   output logic [2:0]      current_flow,
   output logic [2:0]      pole_shut_in,
   output logic            aux_valid,
   output logic            no_chain_shut
);
   logic [2:0] req_q;
   logic [2:0] open_q;
   always_ff @(posedge mclk) begin
      req_q  <= open_req;
      open_q <= req_q;
   end
   assign current_flow  = fault & ~open_q;
   assign pole_shut_in  = aux_stuck ? 3'h7 : ~open_q;
   assign aux_valid     = 1'b1;
   // Series NO chain closed only with every pole closed
   assign no_chain_shut = &pole_shut_in;
endmodule

// File: testbench/bfi_core_props.sv
// Purpose: port assertions for breaker failure initiation
// Assumes: inputs reach the outputs three edges later
// Notes:   settings held steady while a case runs
`timescale 1ns/1ps
module bfi_core_props
   import bfi_pkg::*;
(
   // Clock and reset
   input wire logic           mclk,
   input wire logic           sys_rst,
   // Starts and gating
   input wire logic           cfg_release_assigned,
   input wire logic           int_block,
   input wire logic           int_trip_all,
   input wire logic [NPH-1:0] int_trip_phase,
   input wire logic           int_start_no_current,
   input wire logic           ext_start_all_phases,
   input wire logic           ext_start_phase_a,
   input wire logic           ext_start_phase_b,
   input wire logic           ext_start_phase_c,
   input wire logic           ext_start_no_current,
   input wire logic           ext_release_in,
   input wire logic           ext_block_in,
   input wire logic           breaker_inoperable_in,
   input wire logic [NPH-1:0] pole_shut_in,
   // Outputs
   input wire logic           some_pole_shut,
   input wire logic           all_phase_start,
   input wire logic [NPH-1:0] single_phase_start,
   input wire logic           adjacent_trip,
   input wire logic           intertrip_out
);
   logic any_start;
   logic inop_go;
   logic quiet;
   assign any_start = int_trip_all | (|int_trip_phase) | int_start_no_current
      | ext_start_all_phases | ext_start_phase_a | ext_start_phase_b
      | ext_start_phase_c | ext_start_no_current;
   assign inop_go = breaker_inoperable_in & !ext_block_in & !int_block
      & (ext_release_in | !cfg_release_assigned)
      & (int_trip_all | ext_start_all_phases);
   assign quiet = !all_phase_start && single_phase_start == 3'h0
      && !adjacent_trip;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence inop_held;
      inop_go [*8];
   endsequence
   a_inop_adjacent:
      assert property (inop_held |-> ##[0:4] adjacent_trip)
      else $error("no adjacent trip for inoperable breaker");
   a_intertrip_copy:
      assert property (intertrip_out == adjacent_trip)
      else $error("intertrip differs from adjacent trip");
   a_block_quiet:
      assert property ((ext_block_in | int_block) [*5] |-> quiet)
      else $error("start while blocked");
   a_release_gate:
      assert property ((cfg_release_assigned && !ext_release_in) [*5]
         |-> quiet)
      else $error("start without release");
   a_pole_any:
      assert property ((|pole_shut_in) [*4] |-> some_pole_shut)
      else $error("closed pole not reported");
   a_start_cause:
      assert property (all_phase_start
         |-> $past(any_start, 3) || $past(any_start, 4))
      else $error("start with no trip behind it");
   a_single_alone:
      assert property (single_phase_start != 3'h0
         |-> $onehot(single_phase_start) && !all_phase_start)
      else $error("single-phase start not alone");
   a_idle_clear:
      assert property ((!any_start) [*5] |-> quiet)
      else $error("outputs held after trip withdrawn");
endmodule
bind bfi_core bfi_core_props i_bfi_core_props (.*);

// File: testbench/breaker_failure_initiation_bench.sv
// Purpose: self-checking bench for breaker failure initiation
// Assumes: long delays cannot expire here; zero T3 path is used
// Notes:   rows run twice, external then internal starts
`timescale 1ns/1ps
module breaker_failure_initiation_bench;
   import bfi_pkg::*;
   typedef struct packed {
      logic       seg, chk, rel, blk, t3;
      logic [2:0] tp;
      logic       noi, inop;
      logic [2:0] flt, opn;
      logic       aps;
      logic [2:0] sps;
      logic       adj;
   } bfi_row_t;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       ui = 1'b0;
   logic       ib = 1'b0;
   logic       stuck = 1'b0;
   logic       rel_as = 1'b1;
   logic       ppa = 1'b1;
   bfi_row_t   s = '0;
   bfi_row_t   r;
   int         err_count = 0;
   int         num_checks = 0;
   int         cyc = 0;
   logic [2:0] cf, ps, sps, rtp, stg;
   logic       av, nc, sh, aps, adj, itt;
   bfi_row_t   rows [11] = '{
      21'b0_1_1_0_1_000_0_0_111_000_1_000_0,
      21'b0_1_0_0_1_000_0_0_111_000_0_000_0,
      21'b0_1_1_1_1_000_0_0_111_000_0_000_0,
      21'b0_1_1_0_1_000_0_0_000_111_0_000_0,
      21'b0_1_1_0_1_000_0_0_000_000_1_000_0,
      21'b0_1_1_0_0_000_1_0_000_000_1_000_0,
      21'b1_1_1_0_0_001_0_0_001_000_0_001_0,
      21'b1_1_1_0_0_011_0_0_011_000_1_000_0,
      21'b1_1_1_0_0_000_1_0_000_000_1_000_0,
      21'b1_0_1_0_0_010_0_0_001_000_0_000_0,
      21'b0_1_1_0_1_000_0_1_111_000_1_000_1
   };
   always #2 mclk = ~mclk;
   bfi_breaker_model i_bfi_breaker_model (.mclk, .fault(s.flt),
      .open_req(s.opn), .aux_stuck(stuck), .current_flow(cf),
      .pole_shut_in(ps), .aux_valid(av), .no_chain_shut(nc));
   bfi_core i_bfi_core (.mclk, .sys_rst, .cfg_segregated(s.seg),
      .cfg_two_stage(ui), .cfg_split_t1(ui),
      .use_aux_contact_check(s.chk), .retrip_single_pole_select(1'b0),
      .cfg_release_assigned(rel_as), .cfg_per_pole_aux(ppa),
      .int_block(ib), .int_trip_all(s.t3 & ui),
      .int_trip_phase(s.tp & {3{ui}}), .int_start_no_current(s.noi & ui),
      .ext_start_all_phases(s.t3 & !ui), .ext_start_phase_a(s.tp[0] & !ui),
      .ext_start_phase_b(s.tp[1] & !ui), .ext_start_phase_c(s.tp[2] & !ui),
      .ext_start_no_current(s.noi & !ui), .ext_release_in(s.rel),
      .ext_block_in(s.blk), .breaker_inoperable_in(s.inop),
      .current_flow(cf), .pole_shut_in(ps), .aux_valid(av),
      .no_chain_shut(nc), .some_pole_shut(sh), .all_phase_start(aps),
      .single_phase_start(sps), .local_retrip(rtp), .adjacent_trip(adj),
      .intertrip_out(itt), .stage_state(stg));
   task automatic results;
      if (err_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [5:0] got, input logic [5:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %b want %b", $time, got, exp);
      end
   endtask
   // Clear first so each case starts from an idle breaker
   task automatic run(input bfi_row_t x);
      s = '0;
      repeat (10) @(negedge mclk);
      s = x;
      repeat (12) @(negedge mclk);
      check({aps, sps, adj, itt}, {x.aps, x.sps, x.adj, x.adj});
      check({2'h0, sh, rtp}, {2'h0, |(~x.opn), 3'h0});
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (20) @(negedge mclk);
      check({aps, sps, adj, itt}, 6'h00);
      check({3'h0, stg}, 6'h01);
      sys_rst = 1'b0;
      for (int p = 0; p < 2; p++) begin
         ui = p[0];
         foreach (rows[i]) run(rows[i]);
      end
      ib = 1'b1;
      r = rows[0];
      r.aps = 1'b0;
      run(r);
      ib = 1'b0;
      run(rows[0]);
      check({3'h0, stg}, 6'h02);
      // Contacts stuck closed while the current dies away
      stuck = 1'b1;
      s.opn = 3'h7;
      repeat (12) @(negedge mclk);
      check({aps, sps, adj, itt}, 6'h00);
      check({3'h0, stg}, 6'h01);
      // Single-channel start once release is left unassigned
      stuck = 1'b0;
      rel_as = 1'b0;
      r = rows[1];
      r.aps = 1'b1;
      run(r);
      rel_as = 1'b1;
      // Without per-pole contacts the NO chain stands for the pole
      ppa = 1'b0;
      r = rows[6];
      r.flt = 3'h0;
      run(r);
      r.opn = 3'h2;
      r.sps = 3'h0;
      run(r);
      ppa = 1'b1;
      results();
   end
endmodule
